// ===== shared/range_status_pkg.sv
// Constants, codes and carriers for the over-range event status tree.
// Assumes one system clock; the command parser upstream hands over decoded requests.
`default_nettype none
package range_status_pkg;

  // Register selector codes, one per event register and its enable
  localparam logic [3:0] SEL_INPUT_SUMMARY = 4'h0;
  localparam logic [3:0] SEL_HARM_SUMMARY  = 4'h1;
  localparam logic [3:0] SEL_CHAN_FIRST    = 4'h2;  // first_channel_range_events, 2..7
  localparam logic [3:0] SEL_ANAL_FIRST    = 4'h8;  // first_analyser_range_events, 8..13
  localparam logic [3:0] SEL_FREQ          = 4'he;
  localparam int         REG_COUNT         = 15;
  localparam int         NUM_CH            = 6;
  localparam int         MAX_BOARDS        = 3;

  // Per-channel event bit positions
  localparam int BIT_VOLT_IN   = 0;
  localparam int BIT_CURR_IN   = 1;
  localparam int BIT_POWER_IN  = 2;
  localparam int BIT_VOLT_CF   = 4;
  localparam int BIT_CURR_CF   = 5;
  // Frequency event bit positions
  localparam int BIT_FREQ_A    = 1;
  localparam int BIT_FREQ_B    = 2;
  localparam int BIT_FREQ_C    = 3;
  // Summary bit positions
  localparam int BIT_FREQ_SUM  = 0;
  localparam int BIT_CH1_SUM   = 1;

  // Reset values
  localparam logic [7:0] EVENT_RESET  = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;

  // Register commands from the parser
  typedef enum logic [1:0] {
    OP_READ_EVENT   = 2'b00,
    OP_READ_ENABLE  = 2'b01,
    OP_WRITE_ENABLE = 2'b10,
    OP_CLEAR_STATUS = 2'b11
  } cmd_op_t;

  // Bus interface messages
  typedef enum logic [2:0] {
    MSG_REMOTE = 3'b000,
    MSG_GTL    = 3'b001,
    MSG_LLO    = 3'b010,
    MSG_DCL    = 3'b011,
    MSG_SDC    = 3'b100,
    MSG_GET    = 3'b101
  } bus_msg_t;

  typedef struct packed {
    logic       valid;
    cmd_op_t    op;
    logic [3:0] sel;
    logic [7:0] data;
  } reg_cmd_t;

  typedef struct packed {
    logic     valid;
    bus_msg_t code;
  } bus_msg_req_t;

  // Over-range conditions of one channel
  typedef struct packed {
    logic curr_crest;
    logic volt_crest;
    logic power_in;
    logic curr_in;
    logic volt_in;
  } chan_flags_t;

  typedef struct packed {
    logic c;
    logic b;
    logic a;
  } freq_flags_t;

endpackage
`default_nettype wire

// ===== design/range_event_status_tree.sv
// Over-range event status tree: channel, analyser and frequency event registers,
// their enables, two summary registers and the bus interface message handling.
// Assumes decoded commands and messages arrive on ref_clk; harm_fitted is a pin.
`timescale 1ns/100ps
`default_nettype none

module range_event_status_tree
  import range_status_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire range_status_pkg::reg_cmd_t  cmd,
  input  wire range_status_pkg::bus_msg_req_t msg,
  input  wire range_status_pkg::chan_flags_t [5:0] chan_flags,
  input  wire range_status_pkg::chan_flags_t [5:0] harm_flags,
  input  wire range_status_pkg::freq_flags_t freq_flags,
  input  wire logic [5:0]                  harm_board_sel,
  input  wire logic                        harm_fitted,
  input  wire logic                        meas_hold,
  input  wire logic                        local_key,
  input  wire logic                        key_reset,
  output logic                             rsp_valid,
  output logic [7:0]                       rsp_data,
  output logic                             input_summary_sb,
  output logic                             harm_summary_sb,
  output logic                             remote_state,
  output logic                             panel_keys_off,
  output logic                             flush_io,
  output logic                             single_sample
);
  import range_status_pkg::*;

  // Event and enable storage
  logic [7:0] chan_ev_r [NUM_CH];      // Channel event registers
  logic [7:0] harm_ev_r [NUM_CH];      // Analyser event registers
  logic [7:0] freq_ev_r;               // Frequency event register
  logic [7:0] enable_r [REG_COUNT];    // One enable per register
  logic [7:0] in_sum_r;                // Input summary
  logic [7:0] harm_sum_r;              // Harmonic summary
  // Strap synchroniser and board limit
  logic       fitted_meta_r;           // Option pin, first stage
  logic       fitted_r;                // Option pin, synchronised
  logic [5:0] board_ok;                // Boards allowed to report
  // Decoded register commands
  logic       clr_all;                 // Clear-status command
  logic       rd_event;                // Event query this cycle
  // Interface state and registered outputs
  logic       remote_r;                // Remote state
  logic       lockout_r;               // Panel keys locked
  logic       flush_r;                 // Device clear pulse
  logic       sample_r;                // Single sampling pulse
  logic       rsp_valid_r;             // Answer present
  logic [7:0] rsp_data_r;              // Answer byte
  logic       in_sb_r;                 // Status bit, input summary
  logic       harm_sb_r;               // Status bit, harmonic summary

  assign clr_all  = cmd.valid && (cmd.op == OP_CLEAR_STATUS);
  assign rd_event = cmd.valid && (cmd.op == OP_READ_EVENT);

  // Option-fitted strap crosses from a pin, two flops before use
  // The first flop may go metastable; nothing but the second reads it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fitted_meta_r <= 1'b0;
      fitted_r      <= 1'b0;
    end else begin
      fitted_meta_r <= harm_fitted;
      fitted_r      <= fitted_meta_r;
    end
  end

  // Allow only the lowest three selected boards; guards against a bad selection
  always_comb begin
    int cnt;
    cnt      = 0;
    board_ok = 6'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (harm_board_sel[i] && cnt < MAX_BOARDS) begin
        board_ok[i] = 1'b1;
        cnt         = cnt + 1;
      end
    end
  end

  // Channel layout: unused bits 3,6,7 never set
  function automatic logic [7:0] chan_set(input chan_flags_t f);
    logic [7:0] s;
    s               = 8'h00;
    s[BIT_CURR_CF]  = f.curr_crest;
    s[BIT_VOLT_CF]  = f.volt_crest;
    s[BIT_POWER_IN] = f.power_in;
    s[BIT_CURR_IN]  = f.curr_in;
    s[BIT_VOLT_IN]  = f.volt_in;
    return s;
  endfunction

  // Latch, with set winning over clear from a query or clear-status
  function automatic logic [7:0] ev_next(input logic [7:0] cur,
                                         input logic [7:0] set,
                                         input logic       clr);
    return (clr ? 8'h00 : cur) | set;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic chan_clr;
      logic harm_clr;
      logic [7:0] harm_set;
      assign chan_clr = clr_all || (rd_event && cmd.sel == SEL_CHAN_FIRST + 4'(g));
      assign harm_clr = clr_all || (rd_event && cmd.sel == SEL_ANAL_FIRST + 4'(g));
      // Analyser boards report only when fitted and selected
      assign harm_set = (fitted_r && board_ok[g]) ? chan_set(harm_flags[g]) : 8'h00;

      // Channel event register
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          chan_ev_r[g] <= EVENT_RESET;
        end else begin
          chan_ev_r[g] <= ev_next(chan_ev_r[g], chan_set(chan_flags[g]), chan_clr);
        end
      end

      // Analyser event register, emptied while the option is absent
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          harm_ev_r[g] <= EVENT_RESET;
        end else if (!fitted_r) begin
          harm_ev_r[g] <= EVENT_RESET;
        end else begin
          harm_ev_r[g] <= ev_next(harm_ev_r[g], harm_set, harm_clr);
        end
      end
    end
  endgenerate

  // Frequency event register; bits 0 and 4-7 stay zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      freq_ev_r <= EVENT_RESET;
    end else begin
      freq_ev_r <= ev_next(freq_ev_r,
                           {4'h0, freq_flags.c, freq_flags.b, freq_flags.a, 1'b0},
                           clr_all || (rd_event && cmd.sel == SEL_FREQ));
    end
  end

  // Enable registers, written and read back by the controller
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        enable_r[i] <= ENABLE_RESET;
      end
    end else if (key_reset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        enable_r[i] <= ENABLE_RESET;
      end
    end else if (cmd.valid && cmd.op == OP_WRITE_ENABLE && int'(cmd.sel) < REG_COUNT) begin
      enable_r[cmd.sel] <= cmd.data;
    end
  end

  // Input summary follows the masked children one cycle later
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_sum_r <= EVENT_RESET;
    end else begin
      in_sum_r               <= 8'h00;
      in_sum_r[BIT_FREQ_SUM] <= |(freq_ev_r & enable_r[SEL_FREQ]);
      for (int i = 0; i < NUM_CH; i++) begin
        in_sum_r[BIT_CH1_SUM + i] <=
          |(chan_ev_r[i] & enable_r[SEL_CHAN_FIRST + 4'(i)]);
      end
    end
  end

  // Harmonic summary; bits 0 and 7 stay zero. Gating by the allowed boards
  // keeps at most three bits up after the selection moves on, since older
  // analyser events stay latched until they are read or cleared.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      harm_sum_r <= EVENT_RESET;
    end else begin
      harm_sum_r <= 8'h00;
      for (int i = 0; i < NUM_CH; i++) begin
        harm_sum_r[BIT_CH1_SUM + i] <= fitted_r && board_ok[i] &&
          |(harm_ev_r[i] & enable_r[SEL_ANAL_FIRST + 4'(i)]);
      end
    end
  end

  // Status byte bit of the input summary, masked by its enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_sb_r <= 1'b0;
    end else begin
      in_sb_r <= |(in_sum_r & enable_r[SEL_INPUT_SUMMARY]);
    end
  end

  // Status byte bit of the harmonic summary, masked by its enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      harm_sb_r <= 1'b0;
    end else begin
      harm_sb_r <= |(harm_sum_r & enable_r[SEL_HARM_SUMMARY]);
    end
  end

  // Query answers, one cycle after the request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= 8'h00;
    end else begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= 8'h00;
      if (cmd.valid && int'(cmd.sel) < REG_COUNT) begin
        if (cmd.op == OP_READ_ENABLE) begin
          rsp_valid_r <= 1'b1;
          rsp_data_r  <= enable_r[cmd.sel];
        end else if (cmd.op == OP_READ_EVENT) begin
          rsp_valid_r <= 1'b1;
          if (cmd.sel == SEL_INPUT_SUMMARY) begin
            rsp_data_r <= in_sum_r;
          end else if (cmd.sel == SEL_HARM_SUMMARY) begin
            rsp_data_r <= harm_sum_r;
          end else if (cmd.sel == SEL_FREQ) begin
            rsp_data_r <= freq_ev_r;
          end else if (cmd.sel < SEL_ANAL_FIRST) begin
            rsp_data_r <= chan_ev_r[3'(cmd.sel - SEL_CHAN_FIRST)];
          end else begin
            rsp_data_r <= harm_ev_r[3'(cmd.sel - SEL_ANAL_FIRST)];
          end
        end
      end
    end
  end

  // Remote and lockout state; the local key is dead under lockout
  // No message releases lockout, so only a reset clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      remote_r  <= 1'b0;
      lockout_r <= 1'b0;
    end else if (msg.valid) begin
      unique case (msg.code)
        MSG_REMOTE: remote_r  <= 1'b1;
        MSG_GTL:    remote_r  <= 1'b0;
        MSG_LLO:    lockout_r <= 1'b1;
        default:    remote_r  <= remote_r;
      endcase
    end else if (local_key && !lockout_r) begin
      remote_r <= 1'b0;
    end
  end

  // One-cycle device clear pulse; the parser empties its buffers on it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flush_r <= 1'b0;
    end else begin
      flush_r <= msg.valid && (msg.code == MSG_DCL || msg.code == MSG_SDC);
    end
  end

  // One-cycle trigger pulse; ignored while measurement runs freely
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sample_r <= 1'b0;
    end else begin
      sample_r <= msg.valid && msg.code == MSG_GET && meas_hold;
    end
  end

  assign rsp_valid        = rsp_valid_r;
  assign rsp_data         = rsp_data_r;
  assign input_summary_sb = in_sb_r;
  assign harm_summary_sb  = harm_sb_r;
  assign remote_state     = remote_r;
  assign panel_keys_off   = lockout_r;
  assign flush_io         = flush_r;
  assign single_sample    = sample_r;

endmodule
`default_nettype wire

// ===== tb/range_status_checker.sv
// Port-level checker for the over-range event status tree.
// Assumes one clock domain; bound to the design top below.
`timescale 1ns/100ps
`default_nettype none
module range_status_checker (
  input wire logic                           ref_clk,
  input wire logic                           rst,
  input wire range_status_pkg::reg_cmd_t     cmd,
  input wire range_status_pkg::bus_msg_req_t msg,
  input wire logic                           harm_fitted,
  input wire logic                           meas_hold,
  input wire logic                           rsp_valid,
  input wire logic [7:0]                     rsp_data,
  input wire logic                           harm_summary_sb,
  input wire logic                           remote_state,
  input wire logic                           panel_keys_off,
  input wire logic                           flush_io,
  input wire logic                           single_sample
);
  import range_status_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Either clear message
  wire logic dclr = msg.valid && (msg.code inside {MSG_DCL, MSG_SDC});
  // Trigger message
  wire logic trig = msg.valid && msg.code == MSG_GET;
  // Read on a mapped selector
  wire logic rdq  = cmd.valid && cmd.sel < 4'hf &&
                    (cmd.op inside {OP_READ_EVENT, OP_READ_ENABLE});
  // Query of the harmonic summary
  wire logic rdh  = cmd.valid && cmd.op == OP_READ_EVENT && cmd.sel == SEL_HARM_SUMMARY;
  flush_on_a: assert property (dclr |=> flush_io)
    else $error("flush missing after clear message");
  flush_only_a: assert property (!dclr |=> !flush_io)
    else $error("flush without clear message");
  sample_on_a: assert property (trig && meas_hold |=> single_sample)
    else $error("no sampling pass on trigger while held");
  sample_free_a: assert property (trig && !meas_hold |=> !single_sample)
    else $error("sampling pass on trigger while running");
  local_go_a: assert property (msg.valid && msg.code == MSG_GTL |=> !remote_state)
    else $error("still remote after go-to-local");
  lockout_set_a: assert property (msg.valid && msg.code == MSG_LLO |=> panel_keys_off)
    else $error("keys not locked after lockout");
  lockout_keep_a: assert property (panel_keys_off |=> panel_keys_off)
    else $error("lockout dropped without reset");
  read_answer_a: assert property (rdq |=> rsp_valid)
    else $error("read got no answer");
  no_answer_a: assert property (!rdq |=> !rsp_valid)
    else $error("answer without a read");
  harm_idle_a: assert property (!harm_fitted [*6] |=> !harm_summary_sb)
    else $error("harmonic status set with option absent");
  harm_three_a: assert property (rdh |=> $countones(rsp_data) <= MAX_BOARDS)
    else $error("more than three harmonic summary bits set");
endmodule
bind range_event_status_tree range_status_checker i_chk (.ref_clk, .rst, .cmd, .msg,
  .harm_fitted, .meas_hold, .rsp_valid, .rsp_data, .harm_summary_sb, .remote_state,
  .panel_keys_off, .flush_io, .single_sample);
`default_nettype wire

// ===== tb/gpib_host_model.sv
// Bus controller model: issues register requests and interface messages.
// Assumes a read is answered one cycle after the request edge.
`timescale 1ns/100ps
`default_nettype none
module gpib_host_model (
  input  wire logic                          ref_clk,
  input  wire logic                          rsp_valid,
  input  wire logic [7:0]                    rsp_data,
  output var  range_status_pkg::reg_cmd_t     cmd,
  output var  range_status_pkg::bus_msg_req_t msg
);
  import range_status_pkg::*;
  // Idle from time zero
  initial begin
    cmd = '0;
    msg = '0;
  end
  // One request, held over its taking edge; unanswered gives x
  task automatic reg_op(input cmd_op_t op, input logic [3:0] s,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    #1 cmd = '{1'b1, op, s, d};
    @(posedge ref_clk);
    #1 cmd = '0;
    q = rsp_valid ? rsp_data : 8'hxx;
  endtask
  // One interface message pulse
  task automatic send(input bus_msg_t c);
    @(posedge ref_clk);
    #1 msg = '{1'b1, c};
    @(posedge ref_clk);
    #1 msg = '0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the over-range event status tree.
// Assumes the controller model drives cmd and msg; bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import range_status_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  reg_cmd_t          cmd;
  bus_msg_req_t      msg;
  chan_flags_t [5:0] chan_flags = '0;
  chan_flags_t [5:0] harm_flags = '0;
  freq_flags_t       freq_flags = '0;
  logic [5:0]        harm_board_sel = '0;
  logic              harm_fitted = 1'b0, meas_hold = 1'b0;
  logic              local_key = 1'b0, key_reset = 1'b0;
  logic              rsp_valid, input_summary_sb, harm_summary_sb, remote_state;
  logic              panel_keys_off, flush_io, single_sample;
  logic [7:0]        rsp_data, q;
  int                miscompares = 0, cmp_count = 0, cyc = 0;
  range_event_status_tree i_dut (.ref_clk, .rst, .cmd, .msg, .chan_flags,
    .harm_flags, .freq_flags, .harm_board_sel, .harm_fitted, .meas_hold,
    .local_key, .key_reset, .rsp_valid, .rsp_data, .input_summary_sb,
    .harm_summary_sb, .remote_state, .panel_keys_off, .flush_io, .single_sample);
  gpib_host_model i_host (.ref_clk, .rsp_valid, .rsp_data, .cmd, .msg);
  always #2 ref_clk = ~ref_clk;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  task automatic results;
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read and compare the answer byte; no answer reads as unknown
  task automatic rd(input cmd_op_t op, input logic [3:0] s, input logic [7:0] e);
    i_host.reg_op(op, s, 8'h00, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    i_host.reg_op(OP_WRITE_ENABLE, s, d, q);
  endtask
  // One press of the local key
  task automatic press_local;
    @(posedge ref_clk);
    #1 local_key = 1'b1;
    @(posedge ref_clk);
    #1 local_key = 1'b0;
  endtask
  // Channel flags to event byte; bits 3, 6, 7 stay clear
  function automatic logic [7:0] exp_ch(input logic [4:0] f);
    return {2'b00, f[4:3], 1'b0, f[2:0]};
  endfunction
  task automatic t_enables;
    for (int s = 0; s < REG_COUNT; s++) begin
      rd(OP_READ_EVENT, s[3:0], 8'h00);
      wr(s[3:0], 8'ha0 | 8'(s));
      rd(OP_READ_ENABLE, s[3:0], 8'ha0 | 8'(s));
    end
    i_host.reg_op(OP_READ_EVENT, 4'hf, 8'h00, q);
    chk({7'h0, rsp_valid}, 8'h00);
    @(posedge ref_clk);
    #1 key_reset = 1'b1;
    @(posedge ref_clk);
    #1 key_reset = 1'b0;
    for (int s = 0; s < REG_COUNT; s++) begin
      rd(OP_READ_ENABLE, s[3:0], 8'h00);
    end
  endtask
  task automatic t_chan;
    for (int c = 0; c < NUM_CH; c++) begin
      for (int b = 0; b < 5; b++) begin
        @(posedge ref_clk);
        #1 chan_flags[c] = chan_flags_t'(5'h01 << b);
        @(posedge ref_clk);
        #1 chan_flags[c] = '0;
        rd(OP_READ_EVENT, SEL_CHAN_FIRST + 4'(c), exp_ch(5'h01 << b));
        rd(OP_READ_EVENT, SEL_CHAN_FIRST + 4'(c), 8'h00);
      end
    end
    for (int b = 0; b < 3; b++) begin
      @(posedge ref_clk);
      #1 freq_flags = freq_flags_t'(3'h1 << b);
      @(posedge ref_clk);
      #1 freq_flags = '0;
      rd(OP_READ_EVENT, SEL_FREQ, 8'h02 << b);
    end
  endtask
  // Channel 2 event stays masked out of the summary
  task automatic t_summary;
    wr(SEL_CHAN_FIRST, 8'h01);
    wr(SEL_FREQ, 8'h02);
    wr(SEL_INPUT_SUMMARY, 8'h02);
    @(posedge ref_clk);
    #1 chan_flags[0].volt_in = 1'b1;
    chan_flags[1].curr_in = 1'b1;
    freq_flags.a = 1'b1;
    @(posedge ref_clk);
    #1 chan_flags = '0;
    freq_flags = '0;
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h0, input_summary_sb}, 8'h01);
    rd(OP_READ_EVENT, SEL_INPUT_SUMMARY, 8'h03);
    rd(OP_READ_EVENT, SEL_INPUT_SUMMARY, 8'h03);
    i_host.reg_op(OP_CLEAR_STATUS, 4'h0, 8'h00, q);
    repeat (3) @(posedge ref_clk);
    #1 chk({7'h0, input_summary_sb}, 8'h00);
    rd(OP_READ_EVENT, SEL_CHAN_FIRST + 4'h1, 8'h00);
  endtask
  task automatic t_harm;
    harm_fitted = 1'b1;
    harm_board_sel = 6'h3f;
    for (int s = 0; s < NUM_CH; s++) begin
      wr(SEL_ANAL_FIRST + 4'(s), 8'h01);
    end
    wr(SEL_HARM_SUMMARY, 8'hff);
    @(posedge ref_clk);
    #1 harm_flags = {6{5'h01}};
    @(posedge ref_clk);
    #1 harm_flags = '0;
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h0, harm_summary_sb}, 8'h01);
    rd(OP_READ_EVENT, SEL_HARM_SUMMARY, 8'h0e);
    // Moving the selection must not let old and new boards show together
    harm_board_sel = 6'h38;
    @(posedge ref_clk);
    #1 harm_flags = {6{5'h01}};
    @(posedge ref_clk);
    #1 harm_flags = '0;
    rd(OP_READ_EVENT, SEL_HARM_SUMMARY, 8'h70);
    harm_fitted = 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(OP_READ_EVENT, SEL_HARM_SUMMARY, 8'h00);
  endtask
  task automatic t_msgs;
    i_host.send(MSG_REMOTE);
    chk({7'h0, remote_state}, 8'h01);
    i_host.send(MSG_GTL);
    chk({7'h0, remote_state}, 8'h00);
    i_host.send(MSG_DCL);
    chk({7'h0, flush_io}, 8'h01);
    i_host.send(MSG_SDC);
    chk({7'h0, flush_io}, 8'h01);
    i_host.send(MSG_GET);
    chk({7'h0, single_sample}, 8'h00);
    meas_hold = 1'b1;
    i_host.send(MSG_GET);
    chk({7'h0, single_sample}, 8'h01);
    // Local key works before lockout and is dead after it
    i_host.send(MSG_REMOTE);
    press_local;
    chk({7'h0, remote_state}, 8'h00);
    i_host.send(MSG_REMOTE);
    i_host.send(MSG_LLO);
    press_local;
    chk({7'h0, remote_state}, 8'h01);
    chk({7'h0, panel_keys_off}, 8'h01);
  endtask
  // Mid-run power-on: a latched event and a written enable both return to zero
  task automatic t_reset;
    wr(SEL_FREQ, 8'h0e);
    @(posedge ref_clk);
    #1 freq_flags.c = 1'b1;
    @(posedge ref_clk);
    #1 freq_flags.c = 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    rd(OP_READ_EVENT, SEL_FREQ, 8'h00);
    rd(OP_READ_ENABLE, SEL_FREQ, 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    t_enables;
    t_chan;
    t_summary;
    t_harm;
    t_msgs;
    t_reset;
    results;
  end
endmodule
`default_nettype wire
